/* hw/rtp_pkg.sv */
// constants, state encoding and register image of the remote terminal block
package rtp_pkg;
	// clock rate and derived cycle counts
	localparam int CLK_NS = 10;
	localparam int SLOW_CLK_NS = 1000;
	localparam int DIV_HALF = SLOW_CLK_NS / CLK_NS / 2;
	localparam int CMD_HOLD_NS = 600;
	localparam int CMD_HOLD_CYC = CMD_HOLD_NS / CLK_NS;
	localparam int STAT_SETTLE_NS = 250;
	localparam int STAT_SETTLE_CYC = STAT_SETTLE_NS / CLK_NS;
	localparam int PULSE_NS = 250;
	localparam int PULSE_CYC = PULSE_NS / CLK_NS;
	localparam int RESP_FAST_NS = 4000;
	localparam int RESP_FAST_CYC = RESP_FAST_NS / CLK_NS;
	localparam int RESP_SLOW_NS = 12000;
	localparam int RESP_SLOW_CYC = RESP_SLOW_NS / CLK_NS;
	localparam int MVS_NS = 8500;
	localparam int MVS_CYC = MVS_NS / CLK_NS;
	localparam int BURST_NS = 500;
	localparam int BURST_CYC = BURST_NS / CLK_NS;
	// command word fields and special codes
	localparam int CW_TX = 10;
	localparam logic [4:0] SA_MODE = 5'h00;
	localparam logic [4:0] SA_MODE_ALT = 5'h1F;
	localparam logic [4:0] SA_LOOP = 5'h1E;
	localparam logic [4:0] MC_SYNC = 5'h01;
	localparam logic [4:0] MC_RESET = 5'h08;
	localparam logic [4:0] MC_VECTOR = 5'h10;
	localparam logic [4:0] MC_SYNC_DATA = 5'h11;
	// status word fields
	localparam int ST_ADDR = 11;
	localparam int ST_ME = 10;
	localparam int ST_SR = 8;
	localparam int ST_BUSY = 3;
	localparam int ST_SSF = 2;
	localparam int ST_TF = 0;
	// positions in the synchronised input vector
	localparam int SYNC_COMMAND_FLAG = 18;
	localparam int I_LOAD = 0;
	localparam int I_ME = 1;
	localparam int I_REJ = 2;
	localparam int I_BUSY = 3;
	localparam int I_SR = 4;
	localparam int I_TF = 5;
	localparam int I_SSF = 6;
	localparam int I_LOOP = 7;
	localparam int I_FAST = 8;
	localparam int I_CKEN = 9;
	localparam int I_BYP = 10;
	localparam int I_RST = 11;
	localparam int I_ADDR = 12;
	localparam int I_PAR = 17;

	typedef enum logic [3:0] {S_LATCH, S_IDLE, S_CMD, S_RXD, S_STW, S_RESP, S_STAT, S_MVS,
		S_BURST, S_LOAD, S_TXD, S_VEC, S_SYNC, S_RST} rtp_st_type;

	typedef struct packed {
		logic [SYNC_COMMAND_FLAG-1:0] s1, s2, s3, sv;
		rtp_st_type st;
		logic [10:0] cnt;
		logic [5:0] div;
		logic sclk;
		logic [4:0] addr;
		logic [15:0] cmd, stat, cks, hw, txw;
		logic [5:0] idx, nw;
		logic ill, merr, busy, wrap, from_buf, cks_pin;
		logic hw_en, vcr, live, hdr, mvs, rxs, vec, sync, rdrv, txv;
		logic [31:0][15:0] mem;
	} rtp_regs_type;

	localparam rtp_regs_type RTP_RESET = '0;
endpackage

/* hw/rtp_remote_terminal.sv */
// remote terminal protocol engine with subsystem highway
`timescale 1ns/1ps
// Function
// [R01] latch address at reset, match commands
// [R02] strapped address plus parity is odd; parity is not checked, the parity strap only feeds store released
// [R03] store released when all six straps high
// [R04] loopback keeps subaddress 1E data for echo
// [R05] non-matching next command discards loopback data
// [R06] fast select: 4 us, 1F is data
// [R07] logic runs from one free-running clock
// [R08] output 1 MHz clock, load strobe follows
// [R09] buffer 32 words, validated burst 500 ns
// [R10] subsystem loads words at most 1 us
// [R11] bypass option offers receive words live
// [R12] live strobe low with word on highway
// [R13] message error: flag set, no transfers
// [R14] reject: clear status, no transfers, no data
// [R15] sample discretes after command or last word
// [R16] checksum appended on transmit, checked on receive
// [R17] pulse command flag with command on highway
// [R18] message valid strobe 8.5 us, then burst
// [R19] burst words with receive strobe, 500 ns
// [R20] reset line low resets; reset code drives it
// [R21] vector fetch strobe captures vector word
// [R22] sync flag with data word or zeros
// [R23] busy blocks transfers and data after status; mode commands are not blocked, a vector fetch still sends its word
// [R24] checksum enable is active low
// [R25] checksum pin toggles per word, final is validity
// [R26] synchronise all asynchronous inputs first
module rtp_remote_terminal
	import rtp_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [4:0] addr_strap,
	input wire logic addr_parity_strap,
	input wire logic loopback_select,
	input wire logic fast_response_select,
	input wire logic checksum_enable_n,
	input wire logic buffer_bypass,
	input wire logic message_error_in_n,
	input wire logic command_reject_n,
	input wire logic subsystem_busy_n,
	input wire logic service_request_n,
	input wire logic terminal_flag_n,
	input wire logic subsystem_flag_n,
	input wire logic tx_load_strobe_n,
	input wire logic reset_line_in,
	output logic reset_line_out,
	output logic reset_line_oe_n,
	input wire logic [15:0] highway_in,
	output logic [15:0] highway_out,
	output logic highway_oe_n,
	output logic checksum_status_out,
	output logic checksum_status_oe_n,
	input wire logic bus_word_valid,
	input wire logic bus_word_is_cmd,
	input wire logic bus_word_ok,
	input wire logic [15:0] bus_word,
	input wire logic bus_tx_ready,
	output logic bus_tx_valid,
	output logic [15:0] bus_tx_word,
	output logic slow_clock_out,
	output logic store_released_flag,
	output logic command_received_flag_n,
	output logic live_word_strobe_n,
	output logic header_word_flag_n,
	output logic message_valid_strobe_n,
	output logic rx_word_strobe_n,
	output logic vector_fetch_strobe_n,
	output logic sync_command_flag_n
);
	rtp_regs_type r, n;
	logic [SYNC_COMMAND_FLAG-1:0] pins, agree;
	logic [4:0] sa, mc;
	logic tx, mode, mrx, lb_rx, lfall, ck_on;
	logic [15:0] ck_next;

	// capture discretes into the status word image
	function automatic rtp_regs_type sample_status(input rtp_regs_type x);
		x.ill = !x.sv[I_REJ];
		x.merr = !x.sv[I_ME];
		x.busy = !x.sv[I_BUSY];
		x.stat = '0;
		x.stat[ST_ADDR +: 5] = x.addr;
		x.stat[ST_ME] = x.merr;
		x.stat[ST_SR] = !x.sv[I_SR];
		x.stat[ST_BUSY] = x.busy;
		x.stat[ST_SSF] = !x.sv[I_SSF];
		x.stat[ST_TF] = !x.sv[I_TF];
		return x;
	endfunction

	// ****************************************
	// command decode
	// ****************************************
	assign pins = {addr_parity_strap, addr_strap, reset_line_in, buffer_bypass, checksum_enable_n,
		fast_response_select, loopback_select, subsystem_flag_n, terminal_flag_n,
		service_request_n, subsystem_busy_n, command_reject_n, message_error_in_n,
		tx_load_strobe_n};
	assign tx = r.cmd[CW_TX];
	assign sa = r.cmd[9:5];
	assign mc = r.cmd[4:0];
	assign mode = (sa == SA_MODE) || (sa == SA_MODE_ALT && !r.sv[I_FAST]); // R06
	assign mrx = !tx && !mode;
	assign lb_rx = mrx && r.sv[I_LOOP] && sa == SA_LOOP; // R04
	assign ck_on = !r.sv[I_CKEN]; // R24
	assign ck_next = {r.cks[14:0], r.cks[15]} ^ bus_word;
	// stage agreement and load strobe fall, ahead of the sequencer that reads them
	assign agree = ~(r.s2 ^ r.s3);
	assign lfall = r.sv[I_LOAD] && agree[I_LOAD] && !r.s3[I_LOAD]; // R10

	// ****************************************
	// protocol sequencer
	// ****************************************
	always_comb
	begin
		n = r;
		n.cnt = r.cnt + 11'h1;
		if (!r.sv[I_RST])
			n = RTP_RESET; // R20
		else
			unique case (r.st)
				S_LATCH:
				begin
					n.addr = r.sv[I_ADDR +: 5]; // R01
					n.st = S_IDLE;
				end
				S_IDLE:
					if (bus_word_valid && bus_word_is_cmd && bus_word_ok &&
						bus_word[15:11] == r.addr) // R01
					begin
						n.cmd = bus_word;
						n.hw = bus_word; // R17
						n.hw_en = 1'b1;
						n.vcr = 1'b1;
						n.cnt = '0;
						n.idx = '0;
						n.cks = '0;
						n.nw = (bus_word[4:0] == 5'h00) ? 6'h20 : {1'h0, bus_word[4:0]};
						n.from_buf = r.wrap && bus_word[CW_TX] && bus_word[9:5] == SA_LOOP; // R04
						n.wrap = 1'b0; // R05
						n.st = S_CMD;
					end
				S_CMD:
					if (r.cnt == 11'(CMD_HOLD_CYC - 1))
					begin
						n.vcr = 1'b0;
						n.hw_en = 1'b0;
						n.cnt = '0;
						n.st = S_RXD;
						if (!mrx)
						begin
							n = sample_status(n); // R15
							if (tx || !mc[4])
								n.st = S_RESP;
							else
								n.nw = 6'h01;
						end
					end
				S_RXD:
				begin
					if (r.live && r.cnt == 11'(PULSE_CYC - 1))
					begin
						n.live = 1'b0;
						n.hdr = 1'b0;
						n.hw_en = 1'b0;
					end
					if (bus_word_valid && (bus_word_is_cmd || !bus_word_ok))
					begin
						n.live = 1'b0;
						n.hdr = 1'b0;
						n.hw_en = 1'b0;
						n.st = S_IDLE;
					end
					else if (bus_word_valid)
					begin
						n.mem[r.idx[4:0]] = bus_word; // R09
						n.hw = bus_word;
						n.hw_en = !lb_rx; // R11
						n.live = !lb_rx; // R12
						n.hdr = mrx && !lb_rx && r.idx == 6'h00;
						n.cnt = '0;
						n.cks = ck_next;
						n.cks_pin = ck_on && !r.cks_pin; // R25
						n.idx = r.idx + 6'h1;
						if (r.idx + 6'h1 == r.nw)
						begin
							n.st = S_STW;
							n.cks_pin = ck_on && ck_next == 16'h0000; // R16
						end
					end
				end
				S_STW:
					if (r.cnt == 11'(STAT_SETTLE_CYC - 1))
					begin
						n.live = 1'b0;
						n.hdr = 1'b0;
						n.hw_en = 1'b0;
						n.cnt = '0;
						n.st = S_RESP;
						if (mrx)
							n = sample_status(n); // R15
					end
				S_RESP:
					if (r.cnt == 11'((r.sv[I_FAST] ? RESP_FAST_CYC : RESP_SLOW_CYC) - 1)) // R06
					begin
						n.txv = 1'b1;
						n.txw = r.stat;
						n.st = S_STAT;
					end
				S_STAT:
					if (bus_tx_ready)
					begin
						n.txv = 1'b0;
						n.cnt = '0;
						n.idx = '0;
						n.st = S_IDLE;
						if (r.ill || r.merr)
							n.st = S_IDLE; // R13 R14
						else if (mode)
						begin
							if (mc == MC_RESET)
								n.st = S_RST;
							else if (mc == MC_SYNC || mc == MC_SYNC_DATA)
							begin
								n.sync = 1'b1; // R22
								n.hw = mc[4] ? r.mem[0] : 16'h0000;
								n.hw_en = 1'b1;
								n.st = S_SYNC;
							end
							else if (mc == MC_VECTOR && tx)
							begin
								n.vec = 1'b1; // R21
								n.nw = 6'h01;
								n.from_buf = 1'b0;
								n.st = S_VEC;
							end
						end
						else if (r.busy)
							n.st = S_IDLE; // R23
						else if (lb_rx)
							n.wrap = 1'b1; // R04
						else if (r.from_buf)
						begin
							n.txv = 1'b1;
							n.txw = r.mem[0];
							n.st = S_TXD;
						end
						else if (!(mrx && r.sv[I_BYP])) // R11
						begin
							n.mvs = 1'b1; // R18
							n.hw = r.cmd;
							n.hw_en = 1'b1;
							n.st = S_MVS;
						end
					end
				S_MVS:
					if (r.cnt == 11'(MVS_CYC - 1))
					begin
						n.mvs = 1'b0;
						n.hw_en = 1'b0;
						n.cnt = '0;
						n.st = tx ? S_LOAD : S_BURST;
					end
				S_BURST:
				begin
					if (r.cnt == 11'h000)
					begin
						n.hw = r.mem[r.idx[4:0]]; // R19
						n.hw_en = 1'b1;
						n.rxs = 1'b1;
					end
					if (r.cnt == 11'(PULSE_CYC))
						n.rxs = 1'b0;
					if (r.cnt == 11'(BURST_CYC - 1))
					begin
						n.cnt = '0;
						n.idx = r.idx + 6'h1;
						if (r.idx + 6'h1 == r.nw)
						begin
							n.hw_en = 1'b0;
							n.st = S_IDLE;
						end
					end
				end
				S_LOAD:
					if (ck_on && r.idx + 6'h1 == r.nw)
					begin
						n.txw = {r.cks[14:0], r.cks[15]}; // R16
						n.txv = 1'b1;
						n.st = S_TXD;
					end
					else if (lfall) // R10
					begin
						n.mem[r.idx[4:0]] = highway_in;
						n.txw = highway_in;
						n.cks = {r.cks[14:0], r.cks[15]} ^ highway_in;
						n.txv = 1'b1;
						n.st = S_TXD;
					end
				S_TXD:
					if (bus_tx_ready)
					begin
						n.txv = 1'b0;
						n.idx = r.idx + 6'h1;
						if (r.idx + 6'h1 == r.nw)
							n.st = S_IDLE;
						else if (r.from_buf)
						begin
							n.txv = 1'b1; // R04
							n.txw = r.mem[r.idx[4:0] + 5'h1];
						end
						else
							n.st = S_LOAD;
					end
				S_VEC:
					if (r.cnt == 11'(PULSE_CYC - 1))
					begin
						n.vec = 1'b0;
						n.txw = highway_in; // R21
						n.txv = 1'b1;
						n.st = S_TXD;
					end
				S_SYNC:
					if (r.cnt == 11'(PULSE_CYC - 1))
					begin
						n.sync = 1'b0;
						n.hw_en = 1'b0;
						n.st = S_IDLE;
					end
				S_RST:
					n.rdrv = 1'b1; // R20
			endcase
		// three-stage synchronisers, change taken once stages two and three agree
		n.s1 = pins; // R26
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.sv = (agree & r.s3) | (~agree & r.sv);
		// free-running divider for the subsystem clock
		n.div = r.div + 6'h1;
		if (r.div == 6'(DIV_HALF - 1)) // R08
		begin
			n.div = '0;
			n.sclk = !r.sclk;
		end
	end

	// state register on the single clock
	always_ff @(posedge clk) // R07
	begin
		if (reset)
			r <= RTP_RESET;
		else
			r <= n;
	end

	// ****************************************
	// outputs
	// ****************************************
	assign slow_clock_out = r.sclk;
	assign store_released_flag = &r.sv[I_PAR:I_ADDR]; // R03
	assign command_received_flag_n = !r.vcr;
	assign live_word_strobe_n = !r.live;
	assign header_word_flag_n = !r.hdr;
	assign message_valid_strobe_n = !r.mvs;
	assign rx_word_strobe_n = !r.rxs;
	assign vector_fetch_strobe_n = !r.vec;
	assign sync_command_flag_n = !r.sync;
	assign highway_out = r.hw;
	assign highway_oe_n = !r.hw_en;
	assign reset_line_out = 1'b0;
	assign reset_line_oe_n = !r.rdrv;
	assign checksum_status_out = 1'b0;
	assign checksum_status_oe_n = r.cks_pin || !ck_on; // R25
	assign bus_tx_valid = r.txv;
	assign bus_tx_word = r.txw;

	// ****************************************
	// assertions
	// ****************************************
	logic [10:0] mvs_len;
	always_ff @(posedge clk)
	begin
		if (reset || !r.mvs)
			mvs_len <= '0;
		else
			mvs_len <= mvs_len + 11'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_slow_clk;
		$rose(slow_clock_out) |-> ##50 $fell(slow_clock_out);
	endproperty
	a_slow_clk: assert property (p_slow_clk) else $error("slow clock half period wrong"); // R08
	property p_store_released_flag;
		(&{addr_parity_strap, addr_strap})[*5] |-> store_released_flag;
	endproperty
	a_store_released_flag: assert property (p_store_released_flag) else $error("store released not raised"); // R03
	property p_vcr;
		$fell(command_received_flag_n) |-> !highway_oe_n && highway_out == $past(bus_word);
	endproperty
	a_vcr: assert property (p_vcr) else $error("command not on highway"); // R17
	property p_live;
		$fell(live_word_strobe_n) |-> !highway_oe_n ##1 ($stable(highway_out) && !highway_oe_n)[*8];
	endproperty
	a_live: assert property (p_live) else $error("live word not held"); // R12
	property p_mvs;
		$rose(message_valid_strobe_n) |-> $past(mvs_len) == 11'(MVS_CYC - 1);
	endproperty
	a_mvs: assert property (p_mvs) else $error("message valid strobe length wrong"); // R18
	property p_burst;
		$fell(rx_word_strobe_n) |-> ##25 $rose(rx_word_strobe_n);
	endproperty
	a_burst: assert property (p_burst) else $error("receive strobe width wrong"); // R19
	property p_reject;
		r.st == S_STAT && bus_tx_ready && (r.ill || r.merr) |=> (!bus_tx_valid && highway_oe_n)[*8];
	endproperty
	a_reject: assert property (p_reject) else $error("transfer after illegal message"); // R14
	property p_rst;
		$fell(reset_line_oe_n) |-> $past(r.st, 2) == S_STAT && $past(r.cmd[4:0]) == MC_RESET;
	endproperty
	a_rst: assert property (p_rst) else $error("reset line driven unexpectedly"); // R20
	property p_vec;
		$rose(vector_fetch_strobe_n) |-> bus_tx_valid && bus_tx_word == $past(highway_in);
	endproperty
	a_vec: assert property (p_vec) else $error("vector word not captured"); // R21
	property p_sync;
		$fell(sync_command_flag_n) && r.cmd[4:0] == MC_SYNC |-> highway_out == 16'h0000;
	endproperty
	a_sync: assert property (p_sync) else $error("sync without data not zero"); // R22
	c_burst: cover property ($fell(rx_word_strobe_n));
	c_load: cover property (r.st == S_LOAD && lfall);
	c_vec: cover property ($rose(vector_fetch_strobe_n));
	c_wrap: cover property ($rose(r.wrap));
endmodule

/* testbench/rtp_subsystem_model.sv */
// subsystem model on the highway: loads transmit words and answers vector fetches
`timescale 1ns/1ps
module rtp_subsystem_model
	import rtp_pkg::*;
#(
	parameter logic [15:0] VEC_WORD = 16'hA5C3
)
(
	input wire logic clk,
	input wire logic slow_clock_out,
	input wire logic message_valid_strobe_n,
	input wire logic vector_fetch_strobe_n,
	input wire logic [5:0] load_count,
	input wire logic [15:0] load_base,
	output logic tx_load_strobe_n,
	output logic [15:0] sub_highway
);
	logic mvs_d = 1'b1;
	logic sclk_d = 1'b0;
	logic vec_d = 1'b1;
	logic [5:0] left = 6'h00;
	logic [15:0] word = 16'h0000;
	logic [15:0] last = 16'h0000;
	initial tx_load_strobe_n = 1'b1;
	// loads begin when the valid strobe ends; strobe toggles on slow clock rises
	always @(posedge clk)
	begin
		mvs_d <= message_valid_strobe_n;
		sclk_d <= slow_clock_out;
		vec_d <= vector_fetch_strobe_n;
		last <= sub_highway;
		if (!mvs_d && message_valid_strobe_n)
			left <= load_count;
		else if (!sclk_d && slow_clock_out)
		begin
			if (!tx_load_strobe_n)
				tx_load_strobe_n <= 1'b1;
			else if (left != 6'h00)
			begin
				word <= load_base + 16'(load_count - left);
				left <= left - 6'h01;
				tx_load_strobe_n <= 1'b0;
			end
		end
	end
	// released highway shows a changing pattern, never the last word
	assign sub_highway = (!vector_fetch_strobe_n || !vec_d) ? VEC_WORD :
		(!tx_load_strobe_n ? word : ~last);
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the remote terminal block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top
	import rtp_pkg::*;
;
	typedef struct packed {logic [4:0] a; logic p; logic f;} rtp_row_type;
	localparam logic [15:0] VEC = 16'h5A3C;
	localparam logic [15:0] ST_OK = 16'h2800;
	rtp_row_type rows [4] = '{'{5'h1F, 1'b1, 1'b1}, '{5'h1F, 1'b0, 1'b0},
		'{5'h0F, 1'b1, 1'b0}, '{5'h05, 1'b1, 1'b0}};
	logic clk = 0, reset = 1, addr_parity_strap = 1, loopback_select = 0;
	logic checksum_enable_n = 1, buffer_bypass = 0, cks_oe_n, p_rst = 1;
	int n_rst = 0;
	logic fast_response_select = 0, message_error_in_n = 1, command_reject_n = 1;
	logic subsystem_busy_n = 1, service_request_n = 1, bus_word_valid = 0;
	logic bus_word_is_cmd = 0, bus_tx_ready = 0;
	logic [4:0] addr_strap = 5'h05;
	logic [5:0] load_count = 0;
	logic [15:0] bus_word = 0, load_base = 0, highway_in, highway_out, sub_highway;
	logic [15:0] bus_tx_word, mvs_cmd, sync_w, w, st;
	logic tx_load_strobe_n, reset_line_oe_n, highway_oe_n, bus_tx_valid, slow_clock_out;
	logic store_released_flag, command_received_flag_n, live_word_strobe_n;
	logic header_word_flag_n, message_valid_strobe_n, rx_word_strobe_n;
	logic vector_fetch_strobe_n, sync_command_flag_n;
	logic p_mvs = 1, p_rxs = 1, p_live = 1, p_sync = 1;
	logic [15:0] rxq[$];
	logic [16:0] liveq[$];
	int err_count = 0, tests_run = 0, cyc = 0, n_txv = 0, n_mvs = 0, n_sync = 0;
	int mvs_run = 0, mvs_len = 0, gap = 0, t_rxs = 0, d, m;
	always #5 clk = ~clk;
	assign highway_in = highway_oe_n ? sub_highway : highway_out;
	rtp_remote_terminal DUT (.clk(clk), .reset(reset), .addr_strap(addr_strap),
		.addr_parity_strap(addr_parity_strap), .loopback_select(loopback_select),
		.fast_response_select(fast_response_select), .checksum_enable_n(checksum_enable_n),
		.buffer_bypass(buffer_bypass), .message_error_in_n(message_error_in_n),
		.command_reject_n(command_reject_n), .subsystem_busy_n(subsystem_busy_n),
		.service_request_n(service_request_n), .terminal_flag_n(1'b1),
		.subsystem_flag_n(1'b1), .tx_load_strobe_n(tx_load_strobe_n),
		.reset_line_in(reset_line_oe_n), .reset_line_out(), .reset_line_oe_n(reset_line_oe_n),
		.highway_in(highway_in), .highway_out(highway_out), .highway_oe_n(highway_oe_n),
		.checksum_status_out(), .checksum_status_oe_n(cks_oe_n), .bus_word_valid(bus_word_valid),
		.bus_word_is_cmd(bus_word_is_cmd), .bus_word_ok(1'b1), .bus_word(bus_word),
		.bus_tx_ready(bus_tx_ready), .bus_tx_valid(bus_tx_valid), .bus_tx_word(bus_tx_word),
		.slow_clock_out(slow_clock_out), .store_released_flag(store_released_flag),
		.command_received_flag_n(command_received_flag_n),
		.live_word_strobe_n(live_word_strobe_n), .header_word_flag_n(header_word_flag_n),
		.message_valid_strobe_n(message_valid_strobe_n), .rx_word_strobe_n(rx_word_strobe_n),
		.vector_fetch_strobe_n(vector_fetch_strobe_n),
		.sync_command_flag_n(sync_command_flag_n));
	rtp_subsystem_model #(.VEC_WORD(VEC)) sub (.clk(clk), .slow_clock_out(slow_clock_out),
		.message_valid_strobe_n(message_valid_strobe_n),
		.vector_fetch_strobe_n(vector_fetch_strobe_n), .load_count(load_count),
		.load_base(load_base), .tx_load_strobe_n(tx_load_strobe_n), .sub_highway(sub_highway));
	// ****
	// strobe monitor
	// ****
	always @(posedge clk)
	begin
		cyc++;
		if (bus_tx_valid === 1'b1) n_txv++;
		if (message_valid_strobe_n === 1'b0) mvs_run++;
		else if (mvs_run != 0)
		begin
			mvs_len = mvs_run;
			mvs_run = 0;
			n_mvs++;
		end
		if (p_mvs && !message_valid_strobe_n) mvs_cmd = highway_out;
		if (p_rxs && !rx_word_strobe_n)
		begin
			rxq.push_back(highway_out);
			gap = cyc - t_rxs;
			t_rxs = cyc;
		end
		if (p_live && !live_word_strobe_n) liveq.push_back({header_word_flag_n, highway_out});
		if (p_sync && !sync_command_flag_n)
		begin
			sync_w = highway_out;
			n_sync++;
		end
		p_mvs = message_valid_strobe_n;
		p_rxs = rx_word_strobe_n;
		p_live = live_word_strobe_n;
		p_sync = sync_command_flag_n;
		if (p_rst && !reset_line_oe_n) n_rst++;
		p_rst = reset_line_oe_n;
	end
	// ****
	// bus tasks
	// ****
	task automatic send(input logic [15:0] v, input logic c);
		@(posedge clk);
		bus_word_valid <= 1'b1;
		bus_word <= v;
		bus_word_is_cmd <= c;
		@(posedge clk);
		bus_word_valid <= 1'b0;
		#1;
	endtask
	task automatic get_tx(output logic [15:0] v, output int n);
		n = 0;
		while (bus_tx_valid !== 1'b1 && n < 20000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		`CHK(n < 20000, 1'b1)
		v = bus_tx_word;
		@(posedge clk);
		bus_tx_ready <= 1'b1;
		@(posedge clk);
		bus_tx_ready <= 1'b0;
		#1;
	endtask
	// command, data words spaced 62 cycles, then the status reply
	task automatic msg(input logic [15:0] cmd, input int n, input logic [15:0] base);
		repeat (100) @(posedge clk);
		rxq.delete();
		liveq.delete();
		send(cmd, 1'b1);
		`CHK(command_received_flag_n, 1'b0)
		`CHK(highway_out, cmd)
		`CHK(highway_oe_n, 1'b0)
		for (int i = 0; i < n; i++)
		begin
			repeat (60) @(posedge clk);
			send(base + 16'(i), 1'b0);
		end
		get_tx(st, d);
	endtask
	// nothing further may reach the bus or the subsystem
	task automatic quiet(input int mv);
		int t;
		t = n_txv;
		repeat (3000) @(posedge clk);
		`CHK(n_txv, t)
		`CHK(n_mvs, mv)
		`CHK(rxq.size(), 0)
	endtask
	task automatic give_verdict();
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (90000) @(posedge clk);
		err_count++;
		give_verdict();
	end
	// ****
	// main sequence
	// ****
	initial
	begin
		repeat (20) @(posedge clk);
		`CHK({message_valid_strobe_n, rx_word_strobe_n, bus_tx_valid}, 3'b110)
		reset <= 1'b0;
		repeat (10) @(posedge clk);
		foreach (rows[i])
		begin
			addr_strap <= rows[i].a;
			addr_parity_strap <= rows[i].p;
			repeat (6) @(posedge clk);
			`CHK(store_released_flag, rows[i].f)
		end
		send(16'h3041, 1'b1);
		`CHK(command_received_flag_n, 1'b1)
		msg(16'h2842, 2, 16'h1230);
		`CHK(st, ST_OK)
		`CHK(d >= RESP_SLOW_CYC && d <= RESP_SLOW_CYC + 60, 1'b1)
		`CHK(liveq[0], {1'b0, 16'h1230})
		`CHK(liveq[1], {1'b1, 16'h1231})
		repeat (MVS_CYC + 200) @(posedge clk);
		`CHK(mvs_len, MVS_CYC)
		`CHK(mvs_cmd, 16'h2842)
		`CHK(rxq.size(), 2)
		`CHK(rxq[1], 16'h1231)
		`CHK(gap, BURST_CYC)
		fast_response_select <= 1'b1;
		msg(16'h2BE1, 1, 16'h0BB0);
		`CHK(d >= RESP_FAST_CYC && d <= RESP_FAST_CYC + 60, 1'b1)
		repeat (MVS_CYC + 200) @(posedge clk);
		`CHK(rxq[0], 16'h0BB0)
		fast_response_select <= 1'b0;
		message_error_in_n <= 1'b0;
		service_request_n <= 1'b0;
		m = n_mvs;
		msg(16'h2842, 2, 16'h1000);
		`CHK(st, ST_OK | 16'h0500)
		quiet(m);
		message_error_in_n <= 1'b1;
		service_request_n <= 1'b1;
		command_reject_n <= 1'b0;
		msg(16'h2C42, 0, 16'h0000);
		`CHK(st, ST_OK)
		quiet(m);
		command_reject_n <= 1'b1;
		subsystem_busy_n <= 1'b0;
		msg(16'h2C42, 0, 16'h0000);
		`CHK(st, ST_OK | 16'h0008)
		quiet(m);
		subsystem_busy_n <= 1'b1;
		load_count <= 6'd2;
		load_base <= 16'h4440;
		msg(16'h2C42, 0, 16'h0000);
		get_tx(w, d);
		`CHK(w, 16'h4440)
		get_tx(w, d);
		`CHK(w, 16'h4441)
		load_count <= 6'd0;
		loopback_select <= 1'b1;
		m = n_mvs;
		msg(16'h2BC2, 2, 16'h7700);
		`CHK(liveq.size(), 0)
		msg(16'h2FC2, 0, 16'h0000);
		get_tx(w, d);
		`CHK(w, 16'h7700)
		get_tx(w, d);
		`CHK(w, 16'h7701)
		`CHK(n_mvs, m)
		msg(16'h2BC1, 1, 16'h6600);
		m = n_sync;
		msg(16'h2C01, 0, 16'h0000);
		repeat (100) @(posedge clk);
		`CHK(n_sync, m + 1)
		`CHK(sync_w, 16'h0000)
		load_count <= 6'd1;
		load_base <= 16'h5550;
		msg(16'h2FC1, 0, 16'h0000);
		get_tx(w, d);
		`CHK(w, 16'h5550)
		load_count <= 6'd0;
		msg(16'h2C08, 0, 16'h0000);
		repeat (50) @(posedge clk);
		`CHK(n_rst, 1)
		`CHK(reset_line_oe_n, 1'b1)
		msg(16'h2C10, 0, 16'h0000);
		get_tx(w, d);
		`CHK(w, VEC)
		buffer_bypass <= 1'b1;
		m = n_mvs;
		msg(16'h2842, 2, 16'h3330);
		`CHK(liveq[1], {1'b1, 16'h3331})
		repeat (MVS_CYC + 200) @(posedge clk);
		`CHK(n_mvs, m)
		`CHK(rxq.size(), 0)
		buffer_bypass <= 1'b0;
		checksum_enable_n <= 1'b0;
		load_count <= 6'd1;
		load_base <= 16'h4440;
		msg(16'h2C42, 0, 16'h0000);
		get_tx(w, d);
		`CHK(w, 16'h4440)
		get_tx(w, d);
		`CHK(w, 16'h8880)
		load_count <= 6'd0;
		msg(16'h2842, 2, 16'h0001);
		`CHK(cks_oe_n, 1'b1)
		repeat (MVS_CYC + 200) @(posedge clk);
		msg(16'h2842, 2, 16'h0002);
		`CHK(cks_oe_n, 1'b0)
		repeat (MVS_CYC + 200) @(posedge clk);
		give_verdict();
	end
endmodule
